// *** inc/afr_pkg.sv ***
// Purpose: shared constants of the axis fault response block
// Assumes: 32-bit classic Wishbone, byte addresses below
// Notes:   register byte offsets, codes and reset values
package afr_pkg;
  // ==========================================================
  // sizes
  localparam int          NUM_AXES     = 16;
  localparam int          ADR_W        = 8;
  localparam int          NODE_W       = 7;
  localparam logic [6:0]  NODE_MIN     = 7'h01;
  localparam logic [6:0]  NODE_MAX     = 7'h50;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  OFS_OP       = 8'h00;
  localparam logic [7:0]  OFS_ES_POL   = 8'h04;
  localparam logic [7:0]  OFS_FWD_POL  = 8'h08;
  localparam logic [7:0]  OFS_REV_POL  = 8'h0C;
  localparam logic [7:0]  OFS_STOP_SEL = 8'h10;
  localparam logic [7:0]  OFS_LOCK_REQ = 8'h14;
  localparam logic [7:0]  OFS_ES_ERR   = 8'h18;
  localparam logic [7:0]  OFS_FWD_ERR  = 8'h1C;
  localparam logic [7:0]  OFS_REV_ERR  = 8'h20;
  localparam logic [7:0]  OFS_ALM_ERR  = 8'h24;
  localparam logic [7:0]  OFS_MC_ERR   = 8'h28;
  localparam logic [7:0]  OFS_UNIT     = 8'h2C;
  localparam logic [7:0]  OFS_IRQ_ST   = 8'h30;
  localparam logic [7:0]  OFS_IRQ_MSK  = 8'h34;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_POL      = 16'hFFFF;
  localparam logic [15:0] RST_STOP_SEL = 16'h0000;
  localparam logic [15:0] RST_LOCK_REQ = 16'h0000;
  localparam logic [3:0]  RST_IRQ_MSK  = 4'h0;
  // ==========================================================
  // operation codes
  localparam logic [3:0]  OP_SAVE      = 4'h1;
  localparam logic [3:0]  OP_ERR_RESET = 4'h2;
  // ==========================================================
  // unit register fields
  localparam int          UNIT_MEM_BIT   = 0;
  localparam int          UNIT_UNSET_BIT = 1;
  localparam int          UNIT_NODE_BIT  = 2;
  localparam int          UNIT_NODE_LSB  = 8;
  localparam int          UNIT_SEG_LSB   = 16;
  // ==========================================================
  // interrupt status bits
  localparam int          IRQ_AXIS     = 0;
  localparam int          IRQ_MEM      = 1;
  localparam int          IRQ_NODE     = 2;
  localparam int          IRQ_REJECT   = 3;
  // ==========================================================
  // display prefixes
  localparam logic [7:0]  SEG_MEM      = 8'hE9;
  localparam logic [7:0]  SEG_AE       = 8'hAE;
  localparam logic [7:0]  SEG_NONE     = 8'h00;
endpackage

// *** core/afr_top.sv ***
// Purpose: fault detection and response for sixteen axes
// Assumes: 25 MHz clock, classic Wishbone slave, limit and drive pins asynchronous
// Notes:   nvm and network strobes come from same-clock logic
// Functional notes
// - memory fault shows E9 and lamps
// - memory fault rejects all but save
// - power-up memory fault marks parameters unset
// - slave fault shows AE plus node, held
// - main power loss while locked flags error
// - emergency stop latches error, unlocks servo
// - emergency stop polarity is selectable
// - forward limit latches error, stops axis
// - reverse limit latches error, stops axis
// - each limit has own polarity
// - after forward limit reset, reverse allowed
// - drive alarm latches error, unlocks servo
`timescale 1ns/1ps
module afr_top
  import afr_pkg::*;
(
  input  wire  logic                  clock,
  input  wire  logic                  rst_b,
  input  wire  logic                  wb_cyc_i,
  input  wire  logic                  wb_stb_i,
  input  wire  logic                  wb_we_i,
  input  wire  logic [afr_pkg::ADR_W-1:0] wb_adr_i,
  input  wire  logic [3:0]            wb_sel_i,
  input  wire  logic [31:0]           wb_dat_i,
  output logic       [31:0]           wb_dat_o,
  output logic                        wb_ack_o,
  input  wire  logic [15:0]           estop_in,
  input  wire  logic [15:0]           fwd_limit_in,
  input  wire  logic [15:0]           rev_limit_in,
  input  wire  logic [15:0]           drive_alarm_in,
  input  wire  logic [15:0]           main_power_ok_in,
  input  wire  logic                  nvm_store_fail,
  input  wire  logic                  nvm_corrupt,
  input  wire  logic                  nvm_check_done,
  input  wire  logic                  nvm_save_done,
  input  wire  logic                  slave_fault_stb,
  input  wire  logic [afr_pkg::NODE_W-1:0] slave_fault_node,
  output logic       [15:0]           servo_lock,
  output logic       [15:0]           stop_decel,
  output logic       [15:0]           stop_immediate,
  output logic       [15:0]           fwd_enable,
  output logic       [15:0]           rev_enable,
  output logic                        op_strobe,
  output logic       [3:0]            op_code,
  output logic                        params_unset,
  output logic       [15:0]           segment_display_code,
  output logic                        run_lamp,
  output logic                        unit_error_lamp,
  output logic                        irq
);
  import afr_pkg::*;

  // ==========================================================
  // reset release
  logic rst_m_q, rst_n;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [79:0] pin_m_q, pin_s_q;
  logic [15:0] es_s, fwd_s, rev_s, alm_s, mpw_s;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_q <= 80'h0;
      pin_s_q <= 80'h0;
    end else begin
      pin_m_q <= {estop_in, fwd_limit_in, rev_limit_in, drive_alarm_in, main_power_ok_in};
      pin_s_q <= pin_m_q;
    end
  end
  assign {es_s, fwd_s, rev_s, alm_s, mpw_s} = pin_s_q;

  // ==========================================================
  // bus slave
  logic [15:0] es_pol_q, es_pol_d, fwd_pol_q, fwd_pol_d, rev_pol_q, rev_pol_d;
  logic [15:0] stop_sel_q, stop_sel_d, lock_req_q, lock_req_d;
  logic [3:0]  irq_st_q, irq_st_d, irq_msk_q, irq_msk_d;
  logic [31:0] rd_d, wmask;
  logic        ack_d, wr, wr_op, op_ok, rst_cmd;
  logic [15:0] es_err_q, fwd_err_q, rev_err_q, alm_err_q, mc_err_q, lock_q;
  logic [15:0] es_err_d, fwd_err_d, rev_err_d, alm_err_d, mc_err_d, lock_d;
  logic [15:0] fwd_prev_q, rev_prev_q, es_act, fwd_act, rev_act, pwr_off;
  logic [15:0] stop_dec_d, stop_imm_d, fwd_en_d, rev_en_d;
  logic        mem_err_q, mem_err_d, unset_q, unset_d, pwrup_q, pwrup_d;
  logic        node_err_q, node_err_d, node_take;
  logic [6:0]  node_q, node_d;
  logic [15:0] seg_d;
  logic        axis_evt, op_stb_d;
  logic [3:0]  op_code_d;

  // write lands at the edge where the master samples ack high
  assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_op = wr && (wb_adr_i == OFS_OP) && wb_sel_i[0];
  assign op_ok = wr_op && (!mem_err_q || (wb_dat_i[3:0] == OP_SAVE));
  assign rst_cmd = op_ok && (wb_dat_i[3:0] == OP_ERR_RESET);

  always_comb begin
    ack_d      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    es_pol_d   = es_pol_q;
    fwd_pol_d  = fwd_pol_q;
    rev_pol_d  = rev_pol_q;
    stop_sel_d = stop_sel_q;
    lock_req_d = lock_req_q;
    irq_msk_d  = irq_msk_q;
    if (wr) begin
      if (wb_adr_i == OFS_ES_POL) begin
        es_pol_d = (es_pol_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == OFS_FWD_POL) begin
        fwd_pol_d = (fwd_pol_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == OFS_REV_POL) begin
        rev_pol_d = (rev_pol_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == OFS_STOP_SEL) begin
        stop_sel_d = (stop_sel_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == OFS_LOCK_REQ) begin
        lock_req_d = (lock_req_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == OFS_IRQ_MSK) begin
        irq_msk_d = (irq_msk_q & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
      end
    end
    // status: set wins over write-one clear
    irq_st_d = irq_st_q;
    if (wr && wb_adr_i == OFS_IRQ_ST) begin
      irq_st_d = irq_st_q & ~(wb_dat_i[3:0] & wmask[3:0]);
    end
    irq_st_d[IRQ_AXIS]   = irq_st_d[IRQ_AXIS] | axis_evt;
    irq_st_d[IRQ_MEM]    = irq_st_d[IRQ_MEM] | (mem_err_d & ~mem_err_q);
    irq_st_d[IRQ_NODE]   = irq_st_d[IRQ_NODE] | node_take;
    irq_st_d[IRQ_REJECT] = irq_st_d[IRQ_REJECT] | (wr_op & ~op_ok);
    rd_d = 32'h0;
    if (wb_adr_i == OFS_ES_POL) begin
      rd_d[15:0] = es_pol_q;
    end else if (wb_adr_i == OFS_FWD_POL) begin
      rd_d[15:0] = fwd_pol_q;
    end else if (wb_adr_i == OFS_REV_POL) begin
      rd_d[15:0] = rev_pol_q;
    end else if (wb_adr_i == OFS_STOP_SEL) begin
      rd_d[15:0] = stop_sel_q;
    end else if (wb_adr_i == OFS_LOCK_REQ) begin
      rd_d[15:0] = lock_req_q;
    end else if (wb_adr_i == OFS_ES_ERR) begin
      rd_d[15:0] = es_err_q;
    end else if (wb_adr_i == OFS_FWD_ERR) begin
      rd_d[15:0] = fwd_err_q;
    end else if (wb_adr_i == OFS_REV_ERR) begin
      rd_d[15:0] = rev_err_q;
    end else if (wb_adr_i == OFS_ALM_ERR) begin
      rd_d[15:0] = alm_err_q;
    end else if (wb_adr_i == OFS_MC_ERR) begin
      rd_d[15:0] = mc_err_q;
    end else if (wb_adr_i == OFS_UNIT) begin
      rd_d[UNIT_MEM_BIT]                    = mem_err_q;
      rd_d[UNIT_UNSET_BIT]                  = unset_q;
      rd_d[UNIT_NODE_BIT]                   = node_err_q;
      rd_d[UNIT_NODE_LSB +: 7]              = node_q;
      rd_d[UNIT_SEG_LSB +: 16]              = segment_display_code;
    end else if (wb_adr_i == OFS_IRQ_ST) begin
      rd_d[3:0] = irq_st_q;
    end else if (wb_adr_i == OFS_IRQ_MSK) begin
      rd_d[3:0] = irq_msk_q;
    end
  end

  // ==========================================================
  // per-axis fault response
  genvar i;
  generate
    for (i = 0; i < NUM_AXES; i++) begin : g_axis
      assign es_act[i]  = ~(es_s[i] ^ es_pol_q[i]);
      assign fwd_act[i] = ~(fwd_s[i] ^ fwd_pol_q[i]);
      assign rev_act[i] = ~(rev_s[i] ^ rev_pol_q[i]);
      assign pwr_off[i] = ~mpw_s[i];
      always_comb begin
        es_err_d[i]  = es_act[i] | (es_err_q[i] & ~(rst_cmd & ~es_act[i]));
        alm_err_d[i] = alm_s[i] | (alm_err_q[i] & ~(rst_cmd & ~alm_s[i]));
        mc_err_d[i]  = (pwr_off[i] & lock_q[i])
                     | (mc_err_q[i] & ~(rst_cmd & ~pwr_off[i]));
        fwd_err_d[i] = (fwd_act[i] & ~fwd_prev_q[i]) | (fwd_err_q[i] & ~rst_cmd);
        rev_err_d[i] = (rev_act[i] & ~rev_prev_q[i]) | (rev_err_q[i] & ~rst_cmd);
        lock_d[i]    = lock_req_q[i] & ~es_err_d[i] & ~alm_err_d[i];
        stop_dec_d[i] = (fwd_err_d[i] | rev_err_d[i]) & ~stop_sel_q[i];
        stop_imm_d[i] = (fwd_err_d[i] | rev_err_d[i]) & stop_sel_q[i];
        fwd_en_d[i]  = lock_d[i] & ~fwd_err_d[i] & ~fwd_act[i] & ~rev_err_d[i];
        rev_en_d[i]  = lock_d[i] & ~rev_err_d[i] & ~rev_act[i] & ~fwd_err_d[i];
      end
    end
  endgenerate

  assign axis_evt = |((es_err_d & ~es_err_q) | (fwd_err_d & ~fwd_err_q)
                    | (rev_err_d & ~rev_err_q) | (alm_err_d & ~alm_err_q)
                    | (mc_err_d & ~mc_err_q));

  // ==========================================================
  // unit faults and display
  assign node_take = slave_fault_stb && !node_err_q
                     && (slave_fault_node >= NODE_MIN) && (slave_fault_node <= NODE_MAX);
  always_comb begin
    mem_err_d  = nvm_store_fail | nvm_corrupt | (mem_err_q & ~nvm_save_done);
    pwrup_d    = pwrup_q & ~nvm_check_done;
    unset_d    = (pwrup_q & nvm_check_done & nvm_corrupt) | (unset_q & ~nvm_save_done);
    node_err_d = node_take | (node_err_q & ~rst_cmd);
    node_d     = node_take ? slave_fault_node : node_q;
    op_stb_d   = op_ok;
    op_code_d  = op_ok ? wb_dat_i[3:0] : op_code;
    seg_d      = {SEG_NONE, 8'h00};
    for (int k = NUM_AXES - 1; k >= 0; k--) begin
      if (es_err_q[k] | fwd_err_q[k] | rev_err_q[k] | alm_err_q[k] | mc_err_q[k]) begin
        seg_d = {SEG_AE, 8'(k + 1)};
      end
    end
    if (mem_err_q) begin
      seg_d = {SEG_MEM, 8'h00};
    end else if (node_err_q) begin
      seg_d = {SEG_AE, 1'b0, node_q};
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
      es_pol_q   <= RST_POL;
      fwd_pol_q  <= RST_POL;
      rev_pol_q  <= RST_POL;
      stop_sel_q <= RST_STOP_SEL;
      lock_req_q <= RST_LOCK_REQ;
      irq_st_q   <= 4'h0;
      irq_msk_q  <= RST_IRQ_MSK;
      irq        <= 1'b0;
      es_err_q   <= 16'h0;
      fwd_err_q  <= 16'h0;
      rev_err_q  <= 16'h0;
      alm_err_q  <= 16'h0;
      mc_err_q   <= 16'h0;
      lock_q     <= 16'h0;
      fwd_prev_q <= 16'h0;
      rev_prev_q <= 16'h0;
      servo_lock <= 16'h0;
      stop_decel <= 16'h0;
      stop_immediate <= 16'h0;
      fwd_enable <= 16'h0;
      rev_enable <= 16'h0;
      mem_err_q  <= 1'b0;
      unset_q    <= 1'b0;
      pwrup_q    <= 1'b1;
      node_err_q <= 1'b0;
      node_q     <= 7'h0;
      op_strobe  <= 1'b0;
      op_code    <= 4'h0;
      params_unset <= 1'b0;
      segment_display_code <= 16'h0;
      run_lamp   <= 1'b0;
      unit_error_lamp <= 1'b0;
    end else begin
      wb_ack_o   <= ack_d;
      wb_dat_o   <= rd_d;
      es_pol_q   <= es_pol_d;
      fwd_pol_q  <= fwd_pol_d;
      rev_pol_q  <= rev_pol_d;
      stop_sel_q <= stop_sel_d;
      lock_req_q <= lock_req_d;
      irq_st_q   <= irq_st_d;
      irq_msk_q  <= irq_msk_d;
      irq        <= |(irq_st_d & irq_msk_d);
      es_err_q   <= es_err_d;
      fwd_err_q  <= fwd_err_d;
      rev_err_q  <= rev_err_d;
      alm_err_q  <= alm_err_d;
      mc_err_q   <= mc_err_d;
      lock_q     <= lock_d;
      fwd_prev_q <= fwd_act;
      rev_prev_q <= rev_act;
      servo_lock <= lock_d;
      stop_decel <= stop_dec_d;
      stop_immediate <= stop_imm_d;
      fwd_enable <= fwd_en_d;
      rev_enable <= rev_en_d;
      mem_err_q  <= mem_err_d;
      unset_q    <= unset_d;
      pwrup_q    <= pwrup_d;
      node_err_q <= node_err_d;
      node_q     <= node_d;
      op_strobe  <= op_stb_d;
      op_code    <= op_code_d;
      params_unset <= unset_d;
      segment_display_code <= seg_d;
      run_lamp   <= 1'b1;
      unit_error_lamp <= mem_err_q | node_err_q | (|(es_err_q | fwd_err_q | rev_err_q
                         | alm_err_q | mc_err_q));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_mem_set;
    $rose(mem_err_q);
  endsequence
  property p_mem_show;
    s_mem_set ##1 1 |-> segment_display_code == {SEG_MEM, 8'h00} && unit_error_lamp;
  endproperty
  a_mem_show: assert property (p_mem_show) else $error("memory fault not shown");
  property p_reject;
    wr_op && mem_err_q && wb_dat_i[3:0] != OP_SAVE |=> !op_strobe ##1 irq_st_q[IRQ_REJECT];
  endproperty
  a_reject: assert property (p_reject) else $error("operation not rejected");
  property p_unset;
    pwrup_q && nvm_check_done && nvm_corrupt |=> params_unset && !pwrup_q;
  endproperty
  a_unset: assert property (p_unset) else $error("parameters not marked unset");
  property p_node_hold;
    node_err_q && !rst_cmd |=> node_err_q && $stable(node_q);
  endproperty
  a_node_hold: assert property (p_node_hold) else $error("slave fault not held");
  property p_main;
    |(pwr_off & lock_q) |=> |mc_err_q ##1 segment_display_code[15:8] != SEG_NONE;
  endproperty
  a_main: assert property (p_main) else $error("main power loss missed");
  property p_estop;
    |es_act |=> ((es_err_q & $past(es_act)) == $past(es_act))
                && ((servo_lock & $past(es_act)) == 16'h0);
  endproperty
  a_estop: assert property (p_estop) else $error("estop not latched");
  property p_fwd;
    |(fwd_act & ~fwd_prev_q) |=> |fwd_err_q && |(stop_decel | stop_immediate);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward limit not handled");
  property p_rev;
    |(rev_act & ~rev_prev_q) |=> |rev_err_q && |(stop_decel | stop_immediate);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse limit not handled");
  property p_recover;
    rst_cmd && |fwd_err_q && !(|(fwd_act & ~fwd_prev_q)) |=> (fwd_err_q == 16'h0)
      && (($past(fwd_err_q) & servo_lock & ~$past(rev_act) & ~rev_err_q & ~rev_enable)
          == 16'h0);
  endproperty
  a_recover: assert property (p_recover) else $error("forward recovery wrong");
  property p_alarm;
    |alm_s |=> ((alm_err_q & $past(alm_s)) == $past(alm_s)) && !(|($past(alm_s) & servo_lock));
  endproperty
  a_alarm: assert property (p_alarm) else $error("drive alarm not latched");
  property p_keep;
    rst_cmd && |(alm_err_q & alm_s) |=> |alm_err_q;
  endproperty
  a_keep: assert property (p_keep) else $error("error cleared while cause present");
endmodule

// *** verification/afr_far_model.sv ***
// Purpose: servo drive and network slave stand-in for the fault block
// Assumes: pins change right after a rising clock edge
// Notes:   node bus shows inverted last value when no strobe
`timescale 1ns/1ps
module afr_far_model (
  input  wire logic        clock,
  output logic [15:0]      estop_in,
  output logic [15:0]      fwd_limit_in,
  output logic [15:0]      rev_limit_in,
  output logic [15:0]      drive_alarm_in,
  output logic [15:0]      main_power_ok_in,
  output logic             nvm_store_fail,
  output logic             nvm_corrupt,
  output logic             nvm_check_done,
  output logic             nvm_save_done,
  output logic             slave_fault_stb,
  output logic [6:0]       slave_fault_node
);
  // ==========================================================
  // idle levels
  initial begin
    {estop_in, fwd_limit_in, rev_limit_in, drive_alarm_in} = '0;
    main_power_ok_in = 16'hFFFF;
    {nvm_store_fail, nvm_corrupt, nvm_check_done, nvm_save_done} = 4'h0;
    slave_fault_stb = 1'b0;
    slave_fault_node = 7'h7F;
  end
  // ==========================================================
  // kind 0 estop, 1 fwd, 2 rev, 3 alarm, 4 power
  task automatic set_pin(input int kind, input int axis, input logic lvl);
    @(posedge clock);
    case (kind)
      0: estop_in[axis] <= lvl;
      1: fwd_limit_in[axis] <= lvl;
      2: rev_limit_in[axis] <= lvl;
      3: drive_alarm_in[axis] <= lvl;
      default: main_power_ok_in[axis] <= lvl;
    endcase
  endtask
  // {fail, corrupt, check, save}
  task automatic pulse_nvm(input logic [3:0] v);
    @(posedge clock);
    {nvm_store_fail, nvm_corrupt, nvm_check_done, nvm_save_done} <= v;
    @(posedge clock);
    {nvm_store_fail, nvm_corrupt, nvm_check_done, nvm_save_done} <= 4'h0;
  endtask
  task automatic slave_fault(input logic [6:0] node);
    @(posedge clock);
    slave_fault_stb <= 1'b1;
    slave_fault_node <= node;
    @(posedge clock);
    slave_fault_stb <= 1'b0;
    slave_fault_node <= ~node;
  endtask
endmodule

// *** verification/test_axis_fault_response.sv ***
// Purpose: self-checking bench of the axis fault response block
// Assumes: classic Wishbone master, 25 MHz clock
// Notes:   fixed waits follow the stated pin and strobe latencies
`timescale 1ns/1ps
module test_axis_fault_response;
  import afr_pkg::*;
  logic clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, op_strobe, params_unset;
  logic run_lamp, unit_error_lamp, irq, nvm_store_fail, nvm_corrupt, nvm_check_done;
  logic nvm_save_done, slave_fault_stb;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i, op_code, last_code;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] estop_in, fwd_limit_in, rev_limit_in, drive_alarm_in, main_power_ok_in;
  logic [15:0] servo_lock, stop_decel, stop_immediate, fwd_enable, rev_enable, seg;
  logic [NODE_W-1:0] slave_fault_node;
  int n_errors = 0, checks = 0, n_ops = 0;
  logic [3:0] lanes = 4'hF;
  afr_top uut (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .estop_in(estop_in),
    .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
    .drive_alarm_in(drive_alarm_in), .main_power_ok_in(main_power_ok_in),
    .nvm_store_fail(nvm_store_fail), .nvm_corrupt(nvm_corrupt),
    .nvm_check_done(nvm_check_done), .nvm_save_done(nvm_save_done),
    .slave_fault_stb(slave_fault_stb), .slave_fault_node(slave_fault_node),
    .servo_lock(servo_lock), .stop_decel(stop_decel), .stop_immediate(stop_immediate),
    .fwd_enable(fwd_enable), .rev_enable(rev_enable), .op_strobe(op_strobe),
    .op_code(op_code), .params_unset(params_unset), .segment_display_code(seg),
    .run_lamp(run_lamp), .unit_error_lamp(unit_error_lamp), .irq(irq));
  afr_far_model far (.clock(clock), .estop_in(estop_in), .fwd_limit_in(fwd_limit_in),
    .rev_limit_in(rev_limit_in), .drive_alarm_in(drive_alarm_in),
    .main_power_ok_in(main_power_ok_in), .nvm_store_fail(nvm_store_fail),
    .nvm_corrupt(nvm_corrupt), .nvm_check_done(nvm_check_done),
    .nvm_save_done(nvm_save_done), .slave_fault_stb(slave_fault_stb),
    .slave_fault_node(slave_fault_node));
  // ==========================================================
  // clock and operation monitor
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (op_strobe === 1'b1) begin
      n_ops++;
      last_code = op_code;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= lanes;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      final_report();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0, q);
    chk(q & msk, e);
  endtask
  task automatic clr_err;
    // let a released pin pass the synchroniser first
    repeat (3) @(posedge clock);
    wr(OFS_OP, 32'(OP_ERR_RESET));
    repeat (4) @(posedge clock);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_memory;
    far.pulse_nvm(4'h6);
    repeat (3) @(posedge clock);
    chk(32'(params_unset), 32'h1);
    chk(32'(seg), {16'h0, SEG_MEM, 8'h00});
    chk(32'({run_lamp, unit_error_lamp}), 32'h3);
    wr(OFS_OP, 32'(OP_ERR_RESET));
    repeat (2) @(posedge clock);
    chk(32'(n_ops), 32'h0);
    rd_chk(OFS_IRQ_ST, 32'h8, 32'h8);
    wr(OFS_OP, 32'(OP_SAVE));
    repeat (2) @(posedge clock);
    chk({27'h0, n_ops[0], last_code}, {27'h0, 1'b1, OP_SAVE});
    far.pulse_nvm(4'h1);
    repeat (3) @(posedge clock);
    rd_chk(OFS_UNIT, 32'h3, 32'h0);
    chk(32'(params_unset), 32'h0);
    far.pulse_nvm(4'h8);
    repeat (3) @(posedge clock);
    rd_chk(OFS_UNIT, 32'h1, 32'h1);
    far.pulse_nvm(4'h1);
    wr(OFS_IRQ_ST, 32'hFFFFFFFF);
  endtask
  task automatic t_estop;
    wr(OFS_LOCK_REQ, 32'h0000FFFF);
    wr(OFS_IRQ_MSK, 32'h1);
    far.set_pin(0, 0, 1'b1);
    repeat (6) @(posedge clock);
    chk(32'(servo_lock), 32'h0000FFFE);
    rd_chk(OFS_ES_ERR, 32'hFFFF, 32'h1);
    chk(32'({seg, irq}), {15'h0, SEG_AE, 8'h01, 1'b1});
    clr_err();
    rd_chk(OFS_ES_ERR, 32'hFFFF, 32'h1);
    far.set_pin(0, 0, 1'b0);
    clr_err();
    rd_chk(OFS_ES_ERR, 32'hFFFF, 32'h0);
    wr(OFS_IRQ_ST, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    wr(OFS_ES_POL, 32'h0000FFFE);
    repeat (6) @(posedge clock);
    rd_chk(OFS_ES_ERR, 32'hFFFF, 32'h1);
    wr(OFS_ES_POL, 32'(RST_POL));
    clr_err();
    rd_chk(OFS_ES_ERR, 32'hFFFF, 32'h0);
  endtask
  task automatic t_limits;
    wr(OFS_STOP_SEL, 32'h4);
    far.set_pin(1, 2, 1'b1);
    repeat (6) @(posedge clock);
    rd_chk(OFS_FWD_ERR, 32'hFFFF, 32'h4);
    chk(32'({stop_immediate[2], stop_decel[2]}), 32'h2);
    clr_err();
    rd_chk(OFS_FWD_ERR, 32'hFFFF, 32'h0);
    chk(32'({rev_enable[2], fwd_enable[2]}), 32'h2);
    far.set_pin(1, 2, 1'b0);
    wr(OFS_REV_POL, 32'h0000FFF7);
    repeat (6) @(posedge clock);
    rd_chk(OFS_REV_ERR, 32'hFFFF, 32'h8);
    rd_chk(OFS_FWD_ERR, 32'hFFFF, 32'h0);
    chk(32'({stop_decel[3], stop_immediate[3]}), 32'h2);
    wr(OFS_REV_POL, 32'(RST_POL));
    clr_err();
    rd_chk(OFS_REV_ERR, 32'hFFFF, 32'h0);
    far.set_pin(2, 3, 1'b1);
    repeat (6) @(posedge clock);
    rd_chk(OFS_REV_ERR, 32'hFFFF, 32'h8);
    far.set_pin(2, 3, 1'b0);
    clr_err();
    rd_chk(OFS_REV_ERR, 32'hFFFF, 32'h0);
  endtask
  task automatic t_drive;
    far.set_pin(3, 4, 1'b1);
    far.set_pin(4, 5, 1'b0);
    repeat (6) @(posedge clock);
    rd_chk(OFS_ALM_ERR, 32'hFFFF, 32'h10);
    rd_chk(OFS_MC_ERR, 32'hFFFF, 32'h20);
    chk(32'({servo_lock[4], seg}), {15'h0, 1'b0, SEG_AE, 8'h05});
    far.set_pin(3, 4, 1'b0);
    far.set_pin(4, 5, 1'b1);
    clr_err();
    rd_chk(OFS_ALM_ERR, 32'hFFFF, 32'h0);
    rd_chk(OFS_MC_ERR, 32'hFFFF, 32'h0);
  endtask
  task automatic t_slave;
    far.slave_fault(7'h00);
    far.slave_fault(7'h51);
    repeat (3) @(posedge clock);
    rd_chk(OFS_UNIT, 32'h4, 32'h0);
    far.slave_fault(NODE_MAX);
    far.slave_fault(7'h05);
    repeat (3) @(posedge clock);
    chk(32'(seg), {16'h0, SEG_AE, 8'h50});
    rd_chk(OFS_UNIT, 32'h7F04, 32'h5004);
    clr_err();
    chk(32'(seg), 32'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = '0;
    wb_sel_i = 4'hF;
    wb_dat_i = '0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(OFS_ES_POL, 32'hFFFF, 32'(RST_POL));
    rd_chk(OFS_IRQ_MSK, 32'hF, 32'(RST_IRQ_MSK));
    rd_chk(8'hFC, 32'hFFFFFFFF, 32'h0);
    lanes = 4'h2;
    wr(OFS_STOP_SEL, 32'h0000FFFF);
    lanes = 4'hF;
    rd_chk(OFS_STOP_SEL, 32'hFFFF, 32'hFF00);
    t_memory();
    t_estop();
    t_limits();
    t_drive();
    t_slave();
    final_report();
  end
endmodule
